/* ssa_alu_top.sv */
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
module ssa_alu_top (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic [1:0] o_hresp,
	// Datapath results toward the register file and flag logic
	output logic [31:0] o_dest_data,
	output logic o_dest_we,
	output ssa_pkg::ssa_flags_t o_flags,
	output logic o_flags_upd
);
	typedef struct packed {
		logic [31:0] opa;
		logic [31:0] opb;
		logic [31:0] result;
		ssa_pkg::ssa_flags_t flags;
		logic dest_we;
		logic flags_upd;
		logic last_dest;
		logic last_flag;
		ssa_pkg::ssa_op_t last_op;
		logic [7:0] exec_cnt;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] hrdata;
	} ssa_state_t;

	ssa_state_t st;
	ssa_state_t next_st;

	logic bus_acc;
	logic exec_fire;
	logic exec_cond;
	ssa_pkg::ssa_op_t exec_op;
	logic [31:0] alu_result;
	logic [3:0] alu_ge;
	logic alu_ge_upd;
	ssa_pkg::ssa_flags_t fu_flags;
	logic fu_dest_we;
	logic fu_flags_upd;

	function automatic logic [31:0] rd_word(input ssa_state_t s, input logic [7:0] a);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (a)
			ssa_pkg::ADDR_OPA: w = s.opa;
			ssa_pkg::ADDR_OPB: w = s.opb;
			ssa_pkg::ADDR_RESULT: w = s.result;
			ssa_pkg::ADDR_FLAGS: begin
				w[ssa_pkg::FLG_GE_LSB +: 4] = s.flags.ge;
				w[ssa_pkg::FLG_V_BIT] = s.flags.v;
				w[ssa_pkg::FLG_C_BIT] = s.flags.c;
				w[ssa_pkg::FLG_Z_BIT] = s.flags.z;
				w[ssa_pkg::FLG_N_BIT] = s.flags.n;
			end
			ssa_pkg::ADDR_STATUS: begin
				w[ssa_pkg::ST_DEST_BIT] = s.last_dest;
				w[ssa_pkg::ST_FLAG_BIT] = s.last_flag;
				w[ssa_pkg::ST_OP_LSB +: 3] = s.last_op;
				w[ssa_pkg::ST_CNT_LSB +: 8] = s.exec_cnt;
			end
			// Control is write-only; unmapped words read as zero
			default: w = 32'h0000_0000;
		endcase
		rd_word = w;
	endfunction

	// Only whole-word transfers are taken; others complete with no effect
	assign bus_acc = i_hsel && i_htrans[1] && i_hready && (i_hsize == ssa_pkg::HSIZE_WORD);

	// Execution runs in the data phase of a control write, using its data directly
	assign exec_fire = st.wr_pend && (st.wr_addr == ssa_pkg::ADDR_CTRL);
	assign exec_op = ssa_pkg::ssa_op_t'(i_hwdata[ssa_pkg::CTRL_OP_LSB +: 3]);
	assign exec_cond = exec_fire && i_hwdata[ssa_pkg::CTRL_COND_BIT];

	ssa_lane_alu u_lane_alu (
		.i_op(exec_op),
		.i_src_a(st.opa),
		.i_src_b(st.opb),
		.o_result(alu_result),
		.o_ge(alu_ge),
		.o_ge_upd(alu_ge_upd)
	);

	ssa_flag_unit u_flag_unit (
		.i_op(exec_op),
		.i_cond_pass(exec_cond),
		.i_result(alu_result),
		.i_ge(alu_ge),
		.i_ge_upd(alu_ge_upd),
		.i_shift_carry(i_hwdata[ssa_pkg::CTRL_SHC_BIT]),
		.i_shift_carry_en(i_hwdata[ssa_pkg::CTRL_SHC_EN_BIT]),
		.i_flags(st.flags),
		.o_flags(fu_flags),
		.o_dest_we(fu_dest_we),
		.o_flags_upd(fu_flags_upd)
	);

	always_comb begin
		next_st = st;
		next_st.dest_we = 1'b0;
		next_st.flags_upd = 1'b0;
		if (st.wr_pend) begin
			case (st.wr_addr)
				ssa_pkg::ADDR_OPA: next_st.opa = i_hwdata;
				ssa_pkg::ADDR_OPB: next_st.opb = i_hwdata;
				ssa_pkg::ADDR_FLAGS: begin
					next_st.flags.ge = i_hwdata[ssa_pkg::FLG_GE_LSB +: 4];
					next_st.flags.v = i_hwdata[ssa_pkg::FLG_V_BIT];
					next_st.flags.c = i_hwdata[ssa_pkg::FLG_C_BIT];
					next_st.flags.z = i_hwdata[ssa_pkg::FLG_Z_BIT];
					next_st.flags.n = i_hwdata[ssa_pkg::FLG_N_BIT];
				end
				default: ;
			endcase
		end
		if (exec_fire) begin
			next_st.flags = fu_flags;
			next_st.dest_we = fu_dest_we;
			next_st.flags_upd = fu_flags_upd;
			next_st.last_op = exec_op;
			next_st.last_dest = fu_dest_we;
			next_st.last_flag = fu_flags_upd;
			next_st.exec_cnt = st.exec_cnt + 8'h01;
			// Test results are discarded, so the destination keeps its old value
			if (fu_dest_we) begin
				next_st.result = alu_result;
			end
		end
		next_st.wr_pend = bus_acc && i_hwrite;
		next_st.wr_addr = i_haddr[7:0];
		// Read from next values so a write just before a read is seen at once
		if (bus_acc && !i_hwrite) begin
			next_st.hrdata = rd_word(next_st, i_haddr[7:0]);
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_hrdata = st.hrdata;
	assign o_hreadyout = 1'b1;
	assign o_hresp = ssa_pkg::HRESP_OKAY;
	assign o_dest_data = st.result;
	assign o_dest_we = st.dest_we;
	assign o_flags = st.flags;
	assign o_flags_upd = st.flags_upd;

	// Reference arithmetic for the checks, differences in signed form and sums unsigned
	logic signed [16:0] chk_hd [2];
	logic [16:0] chk_hs [2];
	logic signed [8:0] chk_bd [4];
	logic [8:0] chk_bs [4];
	logic [31:0] chk_bhalf;
	logic [31:0] chk_bsub;
	logic [31:0] chk_bsum;
	logic [3:0] chk_bge;
	logic [3:0] chk_uge;

	genvar k;
	for (k = 0; k < 2; k++) begin : g_chk_half
		assign chk_hd[k] = $signed(st.opa[16*k +: 16]) - $signed(st.opb[16*k +: 16]);
		assign chk_hs[k] = 17'(st.opa[16*k +: 16]) + 17'(st.opb[16*k +: 16]);
	end
	for (k = 0; k < 4; k++) begin : g_chk_byte
		assign chk_bd[k] = $signed(st.opa[8*k +: 8]) - $signed(st.opb[8*k +: 8]);
		assign chk_bs[k] = 9'(st.opa[8*k +: 8]) + 9'(st.opb[8*k +: 8]);
		assign chk_bhalf[8*k +: 8] = chk_bd[k][8:1];
		assign chk_bsub[8*k +: 8] = chk_bd[k][7:0];
		assign chk_bsum[8*k +: 8] = chk_bs[k][7:0];
		assign chk_bge[k] = (chk_bd[k] >= 0);
		assign chk_uge[k] = (chk_bs[k] >= 9'h100);
	end

	logic chk_is_test;
	assign chk_is_test = (exec_op == ssa_pkg::bit_test_op) ||
		(exec_op == ssa_pkg::equivalence_test_op);

	// Test outcome formed apart from the lane datapath
	logic [31:0] chk_test;
	assign chk_test = (exec_op == ssa_pkg::bit_test_op) ? (st.opa & st.opb) : (st.opa ^ st.opb);

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_sys_rst);

	sequence s_run(ssa_pkg::ssa_op_t op);
		exec_cond && (exec_op == op);
	endsequence

	sequence s_cond_fail;
		exec_fire && !exec_cond;
	endsequence

	sequence s_quiet_after;
		!o_dest_we && !o_flags_upd ##0 $stable(o_dest_data) && $stable(o_flags);
	endsequence

	property p_hsub_half;
		s_run(ssa_pkg::halving_signed_sub_half) |=>
			o_dest_data == {$past(chk_hd[1][16:1]), $past(chk_hd[0][16:1])};
	endproperty
	a_hsub_half: assert property (p_hsub_half)
		else $error("halving halfword subtract result wrong");

	property p_hsub_byte;
		s_run(ssa_pkg::halving_signed_sub_byte) |=> o_dest_data == $past(chk_bhalf);
	endproperty
	a_hsub_byte: assert property (p_hsub_byte)
		else $error("halving byte subtract result wrong");

	property p_halving_flags;
		(s_run(ssa_pkg::halving_signed_sub_half) or s_run(ssa_pkg::halving_signed_sub_byte))
			|=> o_dest_we && !o_flags_upd && $stable(o_flags);
	endproperty
	a_halving_flags: assert property (p_halving_flags)
		else $error("halving subtract changed flags");

	property p_ssub_half;
		s_run(ssa_pkg::signed_sub_half) |=>
			o_dest_data == {$past(chk_hd[1][15:0]), $past(chk_hd[0][15:0])};
	endproperty
	a_ssub_half: assert property (p_ssub_half)
		else $error("signed halfword subtract result wrong");

	property p_ssub_half_ge;
		s_run(ssa_pkg::signed_sub_half) |=>
			o_flags.ge == {{2{$past(chk_hd[1] >= 0)}}, {2{$past(chk_hd[0] >= 0)}}};
	endproperty
	a_ssub_half_ge: assert property (p_ssub_half_ge)
		else $error("signed halfword subtract lane flags wrong");

	property p_ssub_byte;
		s_run(ssa_pkg::signed_sub_byte) |=> o_dest_data == $past(chk_bsub);
	endproperty
	a_ssub_byte: assert property (p_ssub_byte)
		else $error("signed byte subtract result wrong");

	property p_ssub_byte_ge;
		s_run(ssa_pkg::signed_sub_byte) |=> o_flags.ge == $past(chk_bge) && o_flags_upd;
	endproperty
	a_ssub_byte_ge: assert property (p_ssub_byte_ge)
		else $error("signed byte subtract lane flags wrong");

	property p_test_no_write;
		exec_cond && chk_is_test |=> !o_dest_we ##0 $stable(o_dest_data);
	endproperty
	a_test_no_write: assert property (p_test_no_write)
		else $error("test operation wrote a destination");

	property p_test_nz;
		exec_cond && chk_is_test |=>
			o_flags.n == $past(chk_test[31]) && o_flags.z == ($past(chk_test) == 32'h0000_0000);
	endproperty
	a_test_nz: assert property (p_test_nz)
		else $error("test operation negative or zero flag wrong");

	property p_test_carry;
		exec_cond && chk_is_test |=> o_flags.c == ($past(i_hwdata[ssa_pkg::CTRL_SHC_EN_BIT]) ?
			$past(i_hwdata[ssa_pkg::CTRL_SHC_BIT]) : $past(o_flags.c));
	endproperty
	a_test_carry: assert property (p_test_carry)
		else $error("test operation carry flag wrong");

	property p_test_v;
		exec_cond && chk_is_test |=> $stable(o_flags.v) && $stable(o_flags.ge);
	endproperty
	a_test_v: assert property (p_test_v)
		else $error("test operation changed overflow flag");

	property p_uadd_half;
		s_run(ssa_pkg::unsigned_add_half) |=>
			o_dest_data == {$past(chk_hs[1][15:0]), $past(chk_hs[0][15:0])};
	endproperty
	a_uadd_half: assert property (p_uadd_half)
		else $error("unsigned halfword add result wrong");

	property p_uadd_half_ge;
		s_run(ssa_pkg::unsigned_add_half) |=> o_flags.ge ==
			{{2{$past(chk_hs[1] >= 17'h10000)}}, {2{$past(chk_hs[0] >= 17'h10000)}}};
	endproperty
	a_uadd_half_ge: assert property (p_uadd_half_ge)
		else $error("unsigned halfword add lane flags wrong");

	property p_uadd_byte;
		s_run(ssa_pkg::unsigned_add_byte) |=> o_dest_data == $past(chk_bsum) && o_dest_we;
	endproperty
	a_uadd_byte: assert property (p_uadd_byte)
		else $error("unsigned byte add result wrong");

	property p_uadd_byte_ge;
		s_run(ssa_pkg::unsigned_add_byte) |=> o_flags.ge == $past(chk_uge);
	endproperty
	a_uadd_byte_ge: assert property (p_uadd_byte_ge)
		else $error("unsigned byte add lane flags wrong");

	property p_cond_fail;
		s_cond_fail |=> s_quiet_after;
	endproperty
	a_cond_fail: assert property (p_cond_fail)
		else $error("failed condition still wrote or changed flags");

	property p_dest_cause;
		o_dest_we |-> $past(exec_cond) && !$past(chk_is_test);
	endproperty
	a_dest_cause: assert property (p_dest_cause)
		else $error("destination write without a passing operation");

	property p_test_upd;
		exec_cond && chk_is_test |=> o_flags_upd;
	endproperty
	a_test_upd: assert property (p_test_upd)
		else $error("test operation did not update flags");

	property p_flag_cause;
		o_flags_upd |-> $past(exec_cond) &&
			$past(exec_op) != ssa_pkg::halving_signed_sub_half &&
			$past(exec_op) != ssa_pkg::halving_signed_sub_byte;
	endproperty
	a_flag_cause: assert property (p_flag_cause)
		else $error("flag update without a passing flag-setting operation");

	property p_dest_hold;
		!o_dest_we |-> $stable(o_dest_data);
	endproperty
	a_dest_hold: assert property (p_dest_hold)
		else $error("destination changed without a write");
endmodule

/* ssa_far_side_model.sv */
`timescale 1ns/1ns
module ssa_far_side_model #(
	// General register that takes results; stack and program counter never named
	parameter logic [3:0] DEST_REG = 4'h1
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	// Results from the datapath
	input wire logic [31:0] i_dest_data,
	input wire logic i_dest_we,
	input wire ssa_pkg::ssa_flags_t i_flags,
	input wire logic i_flags_upd,
	// Counts of accepted writes
	output logic [15:0] o_dest_count,
	output logic [15:0] o_flag_count,
	// What the register file and flag logic last took
	output logic [31:0] o_dest_copy,
	output ssa_pkg::ssa_flags_t o_flag_copy
);
	logic [31:0] reg_file [16];
	ssa_pkg::ssa_flags_t flag_copy;

	assign o_dest_copy = reg_file[DEST_REG];
	assign o_flag_copy = flag_copy;

	// Pulses stand one cycle, so each high sample is one accepted write
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_dest_count <= 16'h0;
			o_flag_count <= 16'h0;
			flag_copy <= '0;
		end else begin
			if (i_dest_we) begin
				reg_file[DEST_REG] <= i_dest_data;
				o_dest_count <= o_dest_count + 16'h1;
			end
			if (i_flags_upd) begin
				flag_copy <= i_flags;
				o_flag_count <= o_flag_count + 16'h1;
			end
		end
	end
endmodule

/* ssa_flag_unit.sv */
`timescale 1ns/1ns
module ssa_flag_unit (
	// Operation and its condition outcome
	input wire ssa_pkg::ssa_op_t i_op,
	input wire logic i_cond_pass,
	// Datapath outcome
	input wire logic [31:0] i_result,
	input wire logic [3:0] i_ge,
	input wire logic i_ge_upd,
	// Carry out of the second operand shifter
	input wire logic i_shift_carry,
	input wire logic i_shift_carry_en,
	// Current flags
	input wire ssa_pkg::ssa_flags_t i_flags,
	// Next flags and write enables
	output ssa_pkg::ssa_flags_t o_flags,
	output logic o_dest_we,
	output logic o_flags_upd
);
	logic is_test;

	assign is_test = (i_op == ssa_pkg::bit_test_op) || (i_op == ssa_pkg::equivalence_test_op);

	always_comb begin
		o_flags = i_flags;
		if (i_cond_pass) begin
			if (i_ge_upd) begin
				o_flags.ge = i_ge;
			end
			if (is_test) begin
				o_flags.n = i_result[31];
				o_flags.z = (i_result == 32'h0000_0000);
				// Without a shifter carry-out the carry flag keeps its value
				if (i_shift_carry_en) begin
					o_flags.c = i_shift_carry;
				end
			end
		end
	end

	// Overflow is never touched here
	assign o_dest_we = i_cond_pass && !is_test;
	assign o_flags_upd = i_cond_pass && (i_ge_upd || is_test);
endmodule

/* ssa_lane_alu.sv */
`timescale 1ns/1ns
module ssa_lane_alu (
	// Operation select
	input wire ssa_pkg::ssa_op_t i_op,
	// Operands
	input wire logic [31:0] i_src_a,
	input wire logic [31:0] i_src_b,
	// Results
	output logic [31:0] o_result,
	output logic [3:0] o_ge,
	output logic o_ge_upd
);
	// One bit wider than the lane so the sign or carry survives
	logic [8:0] byte_diff [4];
	logic [8:0] byte_sum [4];
	logic [16:0] half_diff [2];
	logic [16:0] half_sum [2];

	genvar g;
	for (g = 0; g < 4; g++) begin : g_byte
		assign byte_diff[g] = {i_src_a[8*g+7], i_src_a[8*g +: 8]} - {i_src_b[8*g+7], i_src_b[8*g +: 8]};
		assign byte_sum[g] = {1'b0, i_src_a[8*g +: 8]} + {1'b0, i_src_b[8*g +: 8]};
	end
	for (g = 0; g < 2; g++) begin : g_half
		assign half_diff[g] = {i_src_a[16*g+15], i_src_a[16*g +: 16]} -
			{i_src_b[16*g+15], i_src_b[16*g +: 16]};
		assign half_sum[g] = {1'b0, i_src_a[16*g +: 16]} + {1'b0, i_src_b[16*g +: 16]};
	end

	always_comb begin
		o_result = 32'h0000_0000;
		o_ge = 4'h0;
		o_ge_upd = 1'b0;
		unique case (i_op)
			ssa_pkg::halving_signed_sub_half: begin
				o_result = {half_diff[1][16:1], half_diff[0][16:1]};
			end
			ssa_pkg::halving_signed_sub_byte: begin
				o_result = {byte_diff[3][8:1], byte_diff[2][8:1],
					byte_diff[1][8:1], byte_diff[0][8:1]};
			end
			ssa_pkg::signed_sub_half: begin
				o_result = {half_diff[1][15:0], half_diff[0][15:0]};
				o_ge = {{2{~half_diff[1][16]}}, {2{~half_diff[0][16]}}};
				o_ge_upd = 1'b1;
			end
			ssa_pkg::signed_sub_byte: begin
				o_result = {byte_diff[3][7:0], byte_diff[2][7:0],
					byte_diff[1][7:0], byte_diff[0][7:0]};
				o_ge = {~byte_diff[3][8], ~byte_diff[2][8],
					~byte_diff[1][8], ~byte_diff[0][8]};
				o_ge_upd = 1'b1;
			end
			ssa_pkg::bit_test_op: begin
				o_result = i_src_a & i_src_b;
			end
			ssa_pkg::equivalence_test_op: begin
				o_result = i_src_a ^ i_src_b;
			end
			ssa_pkg::unsigned_add_half: begin
				o_result = {half_sum[1][15:0], half_sum[0][15:0]};
				o_ge = {{2{half_sum[1][16]}}, {2{half_sum[0][16]}}};
				o_ge_upd = 1'b1;
			end
			ssa_pkg::unsigned_add_byte: begin
				o_result = {byte_sum[3][7:0], byte_sum[2][7:0],
					byte_sum[1][7:0], byte_sum[0][7:0]};
				o_ge = {byte_sum[3][8], byte_sum[2][8], byte_sum[1][8], byte_sum[0][8]};
				o_ge_upd = 1'b1;
			end
		endcase
	end
endmodule

/* ssa_pkg.sv */
// Contract
// - Halfword halving subtract: lane differences shifted right
// - Byte halving subtract: four signed halved differences
// - Halving subtracts leave all flags unchanged
// - Halfword signed subtract writes low difference bits
// - Halfword subtract sets lane flag pairs
// - Byte signed subtract writes four low bytes
// - Byte subtract sets lane flag per sign
// - Bit test ANDs, sets flags, no write
// - Equivalence test XORs, sets flags, no write
// - Tests set negative and zero from result
// - Tests change carry only from operand shifter
// - Tests leave overflow flag unchanged
// - Halfword unsigned add writes low sum bits
// - Halfword add sets lane pairs on carry
// - Byte unsigned add writes four low bytes
// - Byte add sets lane flag on carry
package ssa_pkg;

	localparam logic [7:0] ADDR_OPA = 8'h00;
	localparam logic [7:0] ADDR_OPB = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	localparam logic [7:0] ADDR_RESULT = 8'h0c;
	localparam logic [7:0] ADDR_FLAGS = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;

	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_COND_BIT = 4;
	localparam int CTRL_SHC_BIT = 5;
	localparam int CTRL_SHC_EN_BIT = 6;

	localparam int FLG_GE_LSB = 0;
	localparam int FLG_V_BIT = 8;
	localparam int FLG_C_BIT = 9;
	localparam int FLG_Z_BIT = 10;
	localparam int FLG_N_BIT = 11;

	localparam int ST_DEST_BIT = 0;
	localparam int ST_FLAG_BIT = 1;
	localparam int ST_OP_LSB = 4;
	localparam int ST_CNT_LSB = 8;

	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [1:0] HRESP_OKAY = 2'h0;

	typedef enum logic [2:0] {
		halving_signed_sub_half,
		halving_signed_sub_byte,
		signed_sub_half,
		signed_sub_byte,
		bit_test_op,
		equivalence_test_op,
		unsigned_add_half,
		unsigned_add_byte
	} ssa_op_t;

	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
		logic [3:0] ge;
	} ssa_flags_t;

endpackage

/* tb.sv */
`timescale 1ns/1ns
module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = ssa_pkg::HSIZE_WORD;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hready;
	logic [1:0] hresp;
	logic [31:0] dest_data;
	logic dest_we;
	ssa_pkg::ssa_flags_t flags;
	logic flags_upd;
	logic [15:0] dest_count;
	logic [15:0] flag_count;
	logic [31:0] dest_copy;
	ssa_pkg::ssa_flags_t flag_copy;
	int bad_count = 0;
	int checked = 0;
	int cycles = 0;
	logic [31:0] vec_a [4] = '{32'h8000_7fff, 32'hff7f_0180, 32'h1234_5678, 32'hffff_0000};
	logic [31:0] vec_b [4] = '{32'h0001_ffff, 32'h7f80_01ff, 32'h1234_5678, 32'h0001_0000};

	always #5 clk = ~clk;

	ssa_alu_top dut (
		.i_ref_clk(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
		.i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
		.o_dest_data(dest_data), .o_dest_we(dest_we), .o_flags(flags),
		.o_flags_upd(flags_upd)
	);

	ssa_far_side_model far (
		.i_ref_clk(clk), .i_sys_rst(rst), .i_dest_data(dest_data), .i_dest_we(dest_we),
		.i_flags(flags), .i_flags_upd(flags_upd), .o_dest_count(dest_count),
		.o_flag_count(flag_count), .o_dest_copy(dest_copy), .o_flag_copy(flag_copy)
	);

	task automatic final_report();
		if (bad_count == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Zero wait states are not assumed; both phases wait on hready
	task automatic bus_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
			output logic [31:0] rdata);
		hsel <= 1'b1;
		haddr <= {24'h0, addr};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= wdata;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		rdata = hrdata;
	endtask

	task automatic bus_write(input logic [7:0] addr, input logic [31:0] wdata);
		logic [31:0] dummy;
		bus_xfer(1'b1, addr, wdata, dummy);
	endtask

	task automatic read_check(input logic [7:0] addr, input logic [31:0] exp);
		logic [31:0] rd;
		bus_xfer(1'b0, addr, 32'h0, rd);
		check(rd, exp);
	endtask

	function automatic logic [35:0] ref_op(input logic [2:0] op, input logic [31:0] a,
			input logic [31:0] b);
		logic [16:0] d;
		logic [8:0] e;
		logic [31:0] r;
		logic [3:0] g;
		r = 32'h0;
		g = 4'h0;
		for (int i = 0; i < 2; i++) begin
			if (op == 3'h6) d = {1'b0, a[16*i+:16]} + {1'b0, b[16*i+:16]};
			else d = {a[16*i+15], a[16*i+:16]} - {b[16*i+15], b[16*i+:16]};
			if (op == 3'h0) r[16*i+:16] = d[16:1];
			if (op == 3'h2 || op == 3'h6) r[16*i+:16] = d[15:0];
			if (op == 3'h2) g[2*i+:2] = {2{~d[16]}};
			if (op == 3'h6) g[2*i+:2] = {2{d[16]}};
		end
		for (int i = 0; i < 4; i++) begin
			if (op == 3'h7) e = {1'b0, a[8*i+:8]} + {1'b0, b[8*i+:8]};
			else e = {a[8*i+7], a[8*i+:8]} - {b[8*i+7], b[8*i+:8]};
			if (op == 3'h1) r[8*i+:8] = e[8:1];
			if (op == 3'h3 || op == 3'h7) r[8*i+:8] = e[7:0];
			if (op == 3'h3) g[i] = ~e[8];
			if (op == 3'h7) g[i] = e[8];
		end
		if (op == 3'h4) r = a & b;
		if (op == 3'h5) r = a ^ b;
		return {g, r};
	endfunction

	// Hang guard well above the few hundred cycles the sequence needs
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 5000) begin
			bad_count++;
			final_report();
		end
	end

	initial begin
		logic [35:0] ref_v;
		logic [31:0] pre;
		logic [31:0] exp_res;
		logic [7:0] ef;
		logic [7:0] last_ef;
		logic [7:0] cnt;
		logic [2:0] op;
		logic cond;
		logic shen;
		logic shc;
		logic wr;
		logic fu;
		int exp_dest;
		int exp_flag;
		exp_res = ssa_pkg::RST_WORD;
		cnt = 8'h0;
		last_ef = 8'h0;
		exp_dest = 0;
		exp_flag = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		#1;
		check(dest_data, ssa_pkg::RST_WORD);
		check({24'h0, flags}, 32'h0);
		check({30'h0, dest_we, flags_upd}, 32'h0);
		for (int i = 0; i < 6; i++) read_check(8'(4 * i), ssa_pkg::RST_WORD);
		for (int v = 0; v < 4; v++) begin
			for (int k = 0; k < 8; k++) begin
				op = 3'(k);
				cond = (v != 3);
				shen = (v == 1) || (v == 2);
				shc = (v == 2);
				pre = v[0] ? 32'h0000_0f0a : 32'h0000_0105;
				bus_write(ssa_pkg::ADDR_OPA, vec_a[v]);
				bus_write(ssa_pkg::ADDR_OPB, vec_b[v]);
				bus_write(ssa_pkg::ADDR_FLAGS, pre);
				bus_write(ssa_pkg::ADDR_CTRL, {25'h0, shen, shc, cond, 1'b0, op});
				#1;
				ref_v = ref_op(op, vec_a[v], vec_b[v]);
				wr = cond && op != 3'h4 && op != 3'h5;
				fu = cond && op > 3'h1;
				ef = {pre[11:8], pre[3:0]};
				if (fu && (op == 3'h4 || op == 3'h5)) begin
					ef = {ref_v[31], ref_v[31:0] == 32'h0, shen ? shc : pre[9], pre[8], pre[3:0]};
				end else if (fu) begin
					ef = {pre[11:8], ref_v[35:32]};
				end
				if (wr) exp_res = ref_v[31:0];
				if (wr) exp_dest++;
				if (fu) exp_flag++;
				if (fu) last_ef = ef;
				cnt = cnt + 8'h1;
				check({31'h0, dest_we}, {31'h0, wr});
				check({31'h0, flags_upd}, {31'h0, fu});
				check(dest_data, exp_res);
				check({24'h0, flags}, {24'h0, ef});
				read_check(ssa_pkg::ADDR_FLAGS, {20'h0, ef[7:4], 4'h0, ef[3:0]});
				read_check(ssa_pkg::ADDR_RESULT, exp_res);
				read_check(ssa_pkg::ADDR_STATUS, {16'h0, cnt, 1'b0, op, 2'h0, fu, wr});
				check({30'h0, dest_we, flags_upd}, 32'h0);
			end
		end
		read_check(ssa_pkg::ADDR_CTRL, 32'h0);
		read_check(8'h18, 32'h0);
		read_check(ssa_pkg::ADDR_OPA, vec_a[3]);
		check({16'h0, dest_count}, 32'(exp_dest));
		check({16'h0, flag_count}, 32'(exp_flag));
		check(dest_copy, exp_res);
		check({24'h0, flag_copy}, {24'h0, last_ef});
		check({30'h0, hresp}, {30'h0, ssa_pkg::HRESP_OKAY});
		final_report();
	end
endmodule
